// ==== logic/jatten_pkg.sv ====
// Purpose: constants shared by the jitter attenuator path select block
// Assumes: 50 MHz hclk, AHB-Lite word registers
// Notes:   all reset values of control state are zero
package jatten_pkg;
	localparam int NCH          = 4;
	localparam int DEPTH        = 64;
	localparam int CENTER       = 32;
	localparam int REF_DIV      = 16;
	// nco: 256 counts per output bit, REF_DIV ref edges per bit
	localparam int NCO_STEP     = 256 / REF_DIV;
	localparam int CLK_NS       = 20;
	localparam int REF_LOSS_NS  = 16000;
	localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_NS;
	localparam int TX_LOSS_NS   = 3000;
	localparam int TX_LOSS_CYC  = (TX_LOSS_NS + CLK_NS - 1) / CLK_NS;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CFG    = 8'h04;
	localparam logic [7:0] OFF_IMASK  = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_LOOP   = 8'h10;
	localparam logic [7:0] OFF_LIVE   = 8'h14;
	// ctrl fields
	localparam int B_CDR   = 0;
	localparam int B_RXSEL = 1;
	localparam int B_TXSEL = 2;
	localparam int B_GLOBAL_INT_MASK = 4;
	// cfg fields
	localparam int B_LBPRV = 3;
	localparam int B_HZPRV = 4;
	localparam int B_BW    = 5;
	// status/mask: [3:0] driver monitor, [7:4] tx clock loss, [8] ref loss
	localparam int B_DM    = 0;
	localparam int B_TL    = 4;
	localparam int B_RL    = 8;
	localparam int NSTAT   = 9;
	// loop register: [3:0] remote loopback, [7:4] powerdown
	localparam int B_PD    = 4;
	// nco error shift per bandwidth select
	localparam int SH_WIDE = 3;
	localparam int SH_NAR  = 5;
endpackage : jatten_pkg

// ==== logic/jatten_path.sv ====
// Purpose: attenuator path select, elastic store, alarm gating, regs
// Assumes: recovery/encoder strobes on hclk; ref clock and monitor
//          alarms are pins and are synchronised here
// Notes:   ref clock is sampled, so it must stay below hclk/2

////////////////////////////////////////////////////////////////////////
// Operation
// [R1] driver monitor rise interrupts only if channel and global masks clear
// [R2] loopback change without prevent forces tx clock loss, drivers hiz
// [R3] hiz prevent blocks driver monitor alarm while drivers are hiz
// [R4] rx/tx selects are global, powered down channels excluded
// [R5] both selects set disables the single attenuator
// [R6] rx select puts store between recovery and decoder, else bypass
// [R7] rx select ignored while clock recovery is disabled
// [R8] tx select puts store between encoder and pulse control, else bypass
// [R9] bandwidth select narrows the loop corner
// [R10] single pole loop, independent of data pattern
// [R11] gapped tx clock smoothed to even output rate
// [R12] output timing from ref clock over sixteen, 64 entry range
// [R13] tx path tolerates wide input jitter via the 64 entry store
// [R14] system supplies a valid ref clock while attenuation selected
// [R15] driver monitor status latches until read
// [R16] ref clock loss disables attenuator and recovery path
// [R17] 64 entry elastic store, nco read loop, centred on enable
module jatten_path
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             irq,
	// reference clock pin
	input  wire logic        reference_clock,
	output logic             ref_clock_lost,
	// receive: recovery in, decoder out
	input  wire logic [3:0]  rec_stb,
	input  wire logic [3:0]  rec_pos,
	input  wire logic [3:0]  rec_neg,
	output logic [3:0]       dec_stb,
	output logic [3:0]       dec_pos,
	output logic [3:0]       dec_neg,
	// transmit: encoder in, pulse-width control out
	input  wire logic [3:0]  enc_stb,
	input  wire logic [3:0]  enc_pos,
	input  wire logic [3:0]  enc_neg,
	output logic [3:0]       pwc_stb,
	output logic [3:0]       pwc_pos,
	output logic [3:0]       pwc_neg,
	// line driver monitor and high impedance
	input  wire logic [3:0]  driver_monitor_raw,
	output logic [3:0]       line_out_hiz
);
	localparam int N = jatten_pkg::NCH;

	typedef struct packed {
		logic [31:0]                rdata;
		logic                       wph;
		logic [7:0]                 waddr;
		logic                       cdr_en;
		logic                       rx_sel;
		logic                       tx_sel;
		logic                       global_int_mask;
		logic                       lb_prev;
		logic                       hiz_prev;
		logic                       bw_sel;
		logic [jatten_pkg::NSTAT-1:0] imask;
		logic [jatten_pkg::NSTAT-1:0] status;
		logic [N-1:0]               remote_loopback;
		logic [N-1:0]               rl_old;
		logic [N-1:0]               pdown;
		logic [2:0]                 rs;
		logic [9:0]                 ref_cnt;
		logic                       ref_lost;
		logic [N-1:0]               dm1;
		logic [N-1:0]               dm2;
		logic [N-1:0]               dm3;
		logic [N-1:0][7:0]          loss_cnt;
		logic [N-1:0]               hiz;
		logic [N-1:0]               act;
		logic [N-1:0][63:0][1:0]    mem;
		logic [N-1:0][5:0]          wp;
		logic [N-1:0][5:0]          rp;
		logic [N-1:0][7:0]          acc;
		logic [N-1:0]               ds;
		logic [N-1:0]               dp;
		logic [N-1:0]               dn;
		logic [N-1:0]               ts;
		logic [N-1:0]               tp;
		logic [N-1:0]               tn;
	} st_t;

	st_t q;
	st_t d;

	// read value of one register
	function automatic logic [31:0] rd_val(input st_t s, input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			jatten_pkg::OFF_CTRL:
			begin
				v[jatten_pkg::B_CDR]   = s.cdr_en;
				v[jatten_pkg::B_RXSEL] = s.rx_sel;
				v[jatten_pkg::B_TXSEL] = s.tx_sel;
				v[jatten_pkg::B_GLOBAL_INT_MASK] = s.global_int_mask;
			end
			jatten_pkg::OFF_CFG:
			begin
				v[jatten_pkg::B_LBPRV] = s.lb_prev;
				v[jatten_pkg::B_HZPRV] = s.hiz_prev;
				v[jatten_pkg::B_BW]    = s.bw_sel;
			end
			jatten_pkg::OFF_IMASK:  v[8:0] = s.imask;
			jatten_pkg::OFF_STATUS: v[8:0] = s.status;
			jatten_pkg::OFF_LOOP:   v[7:0] = {s.pdown, s.remote_loopback};
			jatten_pkg::OFF_LIVE:   v[8:0] = {s.ref_lost, s.hiz, s.act};
			default:                v = '0;
		endcase
		return v;
	endfunction : rd_val

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		logic        aph;
		logic        edge_r;
		logic        arx;
		logic        atx;
		logic        tick;
		logic        dm_rise;
		logic        tl_old;
		logic [5:0]  fill;
		logic signed [9:0] err;
		logic signed [9:0] sum;
		aph = 1'b0;
		edge_r = 1'b0;
		arx = 1'b0;
		atx = 1'b0;
		tick = 1'b0;
		dm_rise = 1'b0;
		tl_old = 1'b0;
		fill = '0;
		err = '0;
		sum = '0;
		d = q;
		// ahb: zero wait, address captured, write lands in data phase
		aph = hsel & htrans[1] & hready;
		d.wph = aph & hwrite;
		d.waddr = haddr[7:0];
		if (aph & ~hwrite)
		begin
			d.rdata = rd_val(q, haddr[7:0]);
			if (haddr[7:0] == jatten_pkg::OFF_STATUS)
				d.status = '0; // see [R15]
		end
		if (q.wph)
		begin
			case (q.waddr)
				jatten_pkg::OFF_CTRL:
				begin
					d.cdr_en = hwdata[jatten_pkg::B_CDR];
					d.rx_sel = hwdata[jatten_pkg::B_RXSEL];
					d.tx_sel = hwdata[jatten_pkg::B_TXSEL];
					d.global_int_mask  = hwdata[jatten_pkg::B_GLOBAL_INT_MASK];
				end
				jatten_pkg::OFF_CFG:
				begin
					d.lb_prev  = hwdata[jatten_pkg::B_LBPRV];
					d.hiz_prev = hwdata[jatten_pkg::B_HZPRV];
					d.bw_sel   = hwdata[jatten_pkg::B_BW];
				end
				jatten_pkg::OFF_IMASK:  d.imask = hwdata[8:0];
				// build on d so a read clear in this cycle is not undone
				jatten_pkg::OFF_STATUS: d.status = d.status & ~hwdata[8:0];
				jatten_pkg::OFF_LOOP:
				begin
					d.remote_loopback = hwdata[3:0];
					d.pdown = hwdata[7:4];
				end
				default: ;
			endcase
		end
		// ref clock: two flops, then edge detect and loss timer
		d.rs = {q.rs[1:0], reference_clock};
		edge_r = q.rs[1] & ~q.rs[2];
		if (edge_r)
			d.ref_cnt = '0;
		else if (q.ref_cnt != 10'(jatten_pkg::REF_LOSS_CYC))
			d.ref_cnt = q.ref_cnt + 10'h001;
		d.ref_lost = (d.ref_cnt == 10'(jatten_pkg::REF_LOSS_CYC));
		if (d.ref_lost & ~q.ref_lost)
			d.status[jatten_pkg::B_RL] = 1'b1; // set wins over clear
		d.dm1 = driver_monitor_raw;
		d.dm2 = q.dm1;
		d.dm3 = q.dm2;
		d.rl_old = q.remote_loopback;
		d.ds = '0;
		d.ts = '0;
		for (int i = 0; i < N; i++)
		begin
			// global selects, per channel powerdown and ref loss
			arx = q.rx_sel & ~q.tx_sel & q.cdr_en & ~q.pdown[i]
				& ~q.ref_lost; // see [R4] [R5] [R7] [R16]
			atx = q.tx_sel & ~q.rx_sel & ~q.pdown[i]
				& ~q.ref_lost; // see [R4] [R5] [R16]
			d.act[i] = arx | atx;
			// loop error pulls nco toward the centre of the store
			fill = q.wp[i] - q.rp[i];
			err = $signed({4'h0, fill}) - 10'sd32;
			err = q.bw_sel ? (err >>> jatten_pkg::SH_NAR)
				: (err >>> jatten_pkg::SH_WIDE); // see [R9] [R10]
			sum = $signed({2'b00, q.acc[i]})
				+ 10'(jatten_pkg::NCO_STEP) + err;
			tick = 1'b0;
			if (d.act[i] & ~q.act[i])
			begin
				// centre on enable: half of the range in hand
				d.wp[i] = q.rp[i] + 6'(jatten_pkg::CENTER); // see [R17]
				d.acc[i] = '0;
			end
			else if (q.act[i])
			begin
				if (arx ? rec_stb[i] : enc_stb[i])
				begin
					d.mem[i][q.wp[i]] = arx ? {rec_pos[i], rec_neg[i]}
						: {enc_pos[i], enc_neg[i]};
					d.wp[i] = q.wp[i] + 6'h01; // see [R13]
				end
				if (edge_r)
				begin
					// one bit every REF_DIV ref edges, nudged by fill
					d.acc[i] = sum[7:0]; // see [R12] [R11]
					tick = sum[8];
				end
				if (tick)
					d.rp[i] = q.rp[i] + 6'h01;
			end
			// receive: store output or straight through
			if (arx)
			begin
				d.ds[i] = tick; // see [R6]
				{d.dp[i], d.dn[i]} = q.mem[i][q.rp[i]];
			end
			else if (rec_stb[i])
			begin
				d.ds[i] = 1'b1; // see [R6]
				d.dp[i] = rec_pos[i];
				d.dn[i] = rec_neg[i];
			end
			// transmit: smoothed or all tx clock jitter passed
			if (atx)
			begin
				d.ts[i] = tick; // see [R8] [R11]
				{d.tp[i], d.tn[i]} = q.mem[i][q.rp[i]];
			end
			else if (enc_stb[i])
			begin
				d.ts[i] = 1'b1; // see [R8]
				d.tp[i] = enc_pos[i];
				d.tn[i] = enc_neg[i];
			end
			// loopback change transient kills the tx clock for a while
			if ((q.remote_loopback[i] ^ q.rl_old[i]) & ~q.lb_prev)
				d.loss_cnt[i] = 8'(jatten_pkg::TX_LOSS_CYC); // see [R2]
			else if (q.loss_cnt[i] != 8'h00)
				d.loss_cnt[i] = q.loss_cnt[i] - 8'h01;
			// tx store starved of ref clock also loses tx clock
			tl_old = q.hiz[i];
			d.hiz[i] = (d.loss_cnt[i] != 8'h00) | (q.tx_sel & ~q.rx_sel
				& ~q.pdown[i] & q.ref_lost); // see [R2]
			if (d.hiz[i] & ~tl_old)
				d.status[jatten_pkg::B_TL + i] = 1'b1;
			// monitor alarm rise, blocked while drivers are hiz and hiz prevent is set
			dm_rise = q.dm2[i] & ~q.dm3[i]
				& ~(q.hiz[i] & q.hiz_prev); // see [R3]
			if (dm_rise)
				d.status[jatten_pkg::B_DM + i] = 1'b1; // see [R15]
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end

	// outputs; bus never stalls and never errors
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign hrdata         = q.rdata;
	assign irq            = ~q.global_int_mask & |(q.status & ~q.imask); // see [R1]
	assign ref_clock_lost = q.ref_lost;
	assign dec_stb        = q.ds;
	assign dec_pos        = q.dp;
	assign dec_neg        = q.dn;
	assign pwc_stb        = q.ts;
	assign pwc_pos        = q.tp;
	assign pwc_neg        = q.tn;
	assign line_out_hiz   = q.hiz;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_global_int_mask;
		q.global_int_mask |-> !irq;
	endproperty
	a_global_int_mask: assert property (p_global_int_mask) else $error("irq despite global_int_mask"); // see [R1]

	property p_dm_set;
		(q.dm2[0] && !q.dm3[0] && !(q.hiz[0] && q.hiz_prev) && !q.global_int_mask
			&& !q.imask[0]) |=> q.status[0] ##0 irq;
	endproperty
	a_dm_set: assert property (p_dm_set) else $error("dm not raised"); // see [R1]

	property p_hiz_blk;
		(q.hiz_prev && q.hiz[0] && !q.status[0]) |=> !q.status[0];
	endproperty
	a_hiz_blk: assert property (p_hiz_blk) else $error("dm set in hiz"); // see [R3]

	property p_loop_loss;
		(q.remote_loopback[0] != q.rl_old[0] && !q.lb_prev) |=> line_out_hiz[0] [*8];
	endproperty
	a_loop_loss: assert property (p_loop_loss) else $error("no tx loss"); // see [R2]

	property p_both;
		(q.rx_sel && q.tx_sel) |=> q.act == '0;
	endproperty
	a_both: assert property (p_both) else $error("both selects active"); // see [R5]

	property p_cdr;
		(!q.cdr_en && !q.tx_sel) |=> q.act == '0;
	endproperty
	a_cdr: assert property (p_cdr) else $error("rx active without cdr"); // see [R7]

	property p_pdown;
		q.pdown[0] |=> !q.act[0];
	endproperty
	a_pdown: assert property (p_pdown) else $error("active in powerdown"); // see [R4]

	property p_refloss;
		q.ref_lost |=> q.act == '0;
	endproperty
	a_refloss: assert property (p_refloss) else $error("active, no ref"); // see [R16]

	property p_centre;
		$rose(q.act[0]) |-> (q.wp[0] - q.rp[0]) == 6'h20;
	endproperty
	a_centre: assert property (p_centre) else $error("store not centred"); // see [R17]

	property p_bypass;
		(!(q.rx_sel && !q.tx_sel && q.cdr_en && !q.pdown[0] && !q.ref_lost)
			&& rec_stb[0]) |=> dec_stb[0] && dec_pos[0] == $past(rec_pos[0]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("rx bypass broken"); // see [R6]
endmodule : jatten_path

// ==== tb/line_side_model.sv ====
// Purpose: far side model, recovery and encoder streams, ref clock
// Assumes: strobes on hclk, ref clock at hclk/4
// Notes:   ref clock stands still while ref_en is low
module line_side_model
(
	// clock and control
	input  wire logic hclk,
	input  wire logic ref_en,
	// toward the block
	output logic       reference_clock,
	output logic [3:0] rec_stb,
	output logic [3:0] rec_pos,
	output logic [3:0] rec_neg,
	output logic [3:0] enc_stb,
	output logic [3:0] enc_pos,
	output logic [3:0] enc_neg
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt_q = 6'h00;
	logic       ref_q = 1'b0;
	assign reference_clock = ref_q;
	// data changes between strobes, valid only at the strobe
	always @(posedge hclk)
	begin
		cnt_q <= cnt_q + 6'h01;
		if (ref_en && cnt_q[0])
			ref_q <= ~ref_q;
		rec_stb <= {4{cnt_q[2:0] == 3'h0}};
		rec_pos <= cnt_q[5:2];
		rec_neg <= ~cnt_q[5:2] & {4{cnt_q[1]}};
		enc_stb <= {4{cnt_q[2:0] == 3'h4}};
		enc_pos <= ~cnt_q[5:2];
		enc_neg <= cnt_q[5:2] & {4{cnt_q[0]}};
	end
endmodule : line_side_model

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the attenuator path select
// Assumes: hready fed back from hreadyout, one slave
// Notes:   interrupt test runs right after the register test so status starts clean
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, rd;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic        hreadyout, hresp, irq, ref_lost, rclk;
	logic        ref_en = 1'b1;
	logic [3:0]  dm_raw = 4'h0;
	logic [3:0]  hiz, rs, rp, rn, ds, dp, dn, es, ep, en, ps, pp, pn;
	int          err_count = 0;
	int          checked = 0;

	always #10 hclk = ~hclk;

	jatten_path u_jatten_path (.hclk(hclk), .hresetn(hresetn),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.irq(irq), .reference_clock(rclk), .ref_clock_lost(ref_lost),
		.rec_stb(rs), .rec_pos(rp), .rec_neg(rn), .dec_stb(ds),
		.dec_pos(dp), .dec_neg(dn), .enc_stb(es), .enc_pos(ep),
		.enc_neg(en), .pwc_stb(ps), .pwc_pos(pp), .pwc_neg(pn),
		.driver_monitor_raw(dm_raw), .line_out_hiz(hiz));
	line_side_model u_line_side_model (.hclk(hclk), .ref_en(ref_en),
		.reference_clock(rclk), .rec_stb(rs), .rec_pos(rp),
		.rec_neg(rn), .enc_stb(es), .enc_pos(ep), .enc_neg(en));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, e, input string m);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value at %0t: %s %h/%h", $time, m, g, e);
		end
	endtask : chk

	// one single transfer, waits on hready at both phases
	task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr  <= {24'h0000_00, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, 0, "resp");
	endtask : bus

	task automatic rdc(input logic [7:0] a, logic [31:0] e, string m);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
	endtask : rdc

	task automatic t_regs;
		rdc(jatten_pkg::OFF_CTRL, 0, "ctrl rst");
		rdc(jatten_pkg::OFF_STATUS, 0, "status rst");
		bus(1'b1, jatten_pkg::OFF_CFG, 32'h0000_0020);
		rdc(jatten_pkg::OFF_CFG, 32'h0000_0020, "cfg");
		bus(1'b1, 8'h20, 32'hffff_ffff);
		rdc(8'h20, 0, "unmapped");
		bus(1'b1, jatten_pkg::OFF_CFG, 32'h0000_0000);
		$display("test regs done");
	endtask : t_regs

	// monitor rise against channel and global masks
	task automatic t_irq;
		dm_raw <= 4'h1;
		repeat (10) @(posedge hclk);
		chk(irq, 1, "irq");
		rdc(jatten_pkg::OFF_STATUS, 1, "dm set");
		rdc(jatten_pkg::OFF_STATUS, 0, "dm read clr");
		chk(irq, 0, "irq clr");
		dm_raw <= 4'h0;
		bus(1'b1, jatten_pkg::OFF_IMASK, 32'h0000_0001);
		dm_raw <= 4'h1;
		repeat (10) @(posedge hclk);
		chk(irq, 0, "ch mask");
		rdc(jatten_pkg::OFF_STATUS, 1, "masked latch");
		dm_raw <= 4'h0;
		bus(1'b1, jatten_pkg::OFF_IMASK, 32'h0000_0000);
		bus(1'b1, jatten_pkg::OFF_CTRL, 32'h0000_0010);
		dm_raw <= 4'h1;
		repeat (10) @(posedge hclk);
		chk(irq, 0, "global_int_mask");
		rdc(jatten_pkg::OFF_STATUS, 1, "global_int_mask latch");
		bus(1'b1, jatten_pkg::OFF_CTRL, 32'h0000_0000);
		dm_raw <= 4'h0;
		$display("test irq done");
	endtask : t_irq

	// bypassed channels pass each strobe one edge later; freshly
	// enabled channels stay quiet until sixteen ref edges have passed
	task automatic t_path(input logic [31:0] c, l, logic [3:0] rm,
		tm, lv, hm);
		logic [11:0] r;
		logic [11:0] t;
		bus(1'b1, jatten_pkg::OFF_CTRL, c);
		bus(1'b1, jatten_pkg::OFF_LOOP, l);
		rdc(jatten_pkg::OFF_LIVE, {28'h0000_000, lv}, "live");
		r = {rs, rp, rn};
		t = {es, ep, en};
		repeat (40)
		begin
			@(posedge hclk);
			chk({ds, dp & r[11:8], dn & r[11:8]} & {3{rm}},
				r & {3{r[11:8] & rm}}, "rx");
			chk({ps, pp & t[11:8], pn & t[11:8]} & {3{tm}},
				t & {3{t[11:8] & tm}}, "tx");
			chk((ds & ~rm | ps & ~tm) & hm, 0, "held");
			r = {rs, rp, rn};
			t = {es, ep, en};
		end
		$display("test path done");
	endtask : t_path

	// loopback change forces hiz; hiz prevent blocks the monitor
	task automatic t_loop;
		bus(1'b1, jatten_pkg::OFF_CFG, 32'h0000_0010);
		bus(1'b1, jatten_pkg::OFF_LOOP, 32'h0000_0001);
		repeat (3) @(posedge hclk);
		chk(hiz, 4'h1, "hiz");
		// write one clears the tx loss flag before the monitor rises
		bus(1'b1, jatten_pkg::OFF_STATUS, 32'h0000_0010);
		dm_raw <= 4'h1;
		repeat (10) @(posedge hclk);
		rdc(jatten_pkg::OFF_STATUS, 0, "hiz prevent");
		dm_raw <= 4'h0;
		repeat (160) @(posedge hclk);
		chk(hiz, 0, "hiz end");
		bus(1'b1, jatten_pkg::OFF_CFG, 32'h0000_0008);
		bus(1'b1, jatten_pkg::OFF_LOOP, 32'h0000_0000);
		repeat (3) @(posedge hclk);
		chk(hiz, 0, "lb prevent");
		rdc(jatten_pkg::OFF_STATUS, 0, "no tx loss");
		$display("test loop done");
	endtask : t_loop

	task automatic t_ref;
		bus(1'b1, jatten_pkg::OFF_CTRL, 32'h0000_0003);
		ref_en <= 1'b0;
		repeat (820) @(posedge hclk);
		chk(ref_lost, 1, "ref lost");
		rdc(jatten_pkg::OFF_LIVE, 32'h0000_0100, "live lost");
		rdc(jatten_pkg::OFF_STATUS, 32'h0000_0100, "lost");
		ref_en <= 1'b1;
		repeat (20) @(posedge hclk);
		chk(ref_lost, 0, "ref back");
		$display("test ref done");
	endtask : t_ref

	task automatic print_verdict;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_irq;
		t_path(0, 0, 4'hf, 4'hf, 4'h0, 4'h0);
		t_path(3, 0, 4'h0, 4'hf, 4'hf, 4'hf);
		t_path(3, 32'h10, 4'h1, 4'hf, 4'he, 4'h0);
		t_path(2, 0, 4'hf, 4'hf, 4'h0, 4'h0);
		t_path(5, 0, 4'hf, 4'h0, 4'hf, 4'hf);
		t_path(7, 0, 4'hf, 4'hf, 4'h0, 4'h0);
		t_loop;
		t_ref;
		print_verdict;
	end

	// watchdog well beyond the expected run length
	initial
	begin
		#200000;
		err_count++;
		print_verdict;
	end
endmodule : tb_top
